// [rtl/sicu_pkg.sv]
// constants shared by the synthesizer programming controller and its bus engine
// assumes a 125 MHz pclk and an open-drain two-wire bus resolved outside
package sicu_pkg;
    // register map, one aligned 32-bit word each
    localparam logic [7:0] OFF_DIV = 8'h00;
    localparam logic [7:0] OFF_LOOP = 8'h04;
    localparam logic [7:0] OFF_DSW = 8'h08;
    localparam logic [7:0] OFF_CONV = 8'h0c;
    localparam logic [7:0] OFF_CMD = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    // field positions
    localparam int DIV_RD_FIRST_BIT = 16;
    localparam int DIV_RD_SECOND_BIT = 15;
    localparam int CMD_FIRST_LSB = 0;
    localparam int CMD_LAST_LSB = 2;
    localparam int CMD_AS_LSB = 4;
    localparam int CMD_GO_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_ERR_BIT = 3;
    // reset values
    localparam logic [16:0] DIV_RESET = 17'h00000;
    localparam logic [4:0] LOOP_RESET = 5'h00;
    localparam logic [5:0] DSW_RESET = 6'h00;
    localparam logic [15:0] CONV_RESET = 16'h0000;
    // byte layout on the wire
    localparam logic [4:0] ADDR_PREFIX = 5'h18;
    localparam logic [2:0] CTRL_PREFIX = 3'h6;
    localparam logic [1:0] CONV_PREFIX = 2'h2;
    localparam logic [14:0] MIN_FACTOR = 15'h0800;
    localparam logic [1:0] GRP_DIV = 2'h0;
    localparam logic [1:0] GRP_CONV = 2'h2;
    // engine operations
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_STOP = 2'h2;
    // timing: one quarter of a 100 kHz bit period
    localparam int SCL_QTR_NS = 2500;
    localparam int CLK_MHZ = 125;
    localparam int QTR_CYC = (SCL_QTR_NS * CLK_MHZ + 999) / 1000;
endpackage

// [rtl/sicu_i2c_engine.sv]
// bit-level engine: start, one byte with acknowledge slot, stop
// assumes the bus pull-ups are outside; oe high pulls the line low
`timescale 1ns/1ns
module sicu_i2c_engine import sicu_pkg::*; #(
    parameter int QTR = QTR_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // command side
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_byte,
    output logic cmd_ready,
    output logic done,
    output logic nack,
    // bus pins
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe
);
    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_START = 2'b01,
        E_BIT = 2'b10,
        E_STOP = 2'b11
    } sicu_estate_t;

    sicu_estate_t st_ff, nxt_st;
    logic [1:0] ph_ff, nxt_ph;
    logic [3:0] bit_ff, nxt_bit;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
    logic done_ff, nxt_done, nack_ff, nxt_nack;
    logic s1_ff, s2_ff;
    logic tick;

    assign tick = (cnt_ff == 16'(QTR - 1));
    assign cmd_ready = (st_ff == E_IDLE);
    assign done = done_ff;
    assign nack = nack_ff;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_ff;
    assign sda_oe = sda_oe_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_ph = ph_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_nack = nack_ff;
        nxt_done = 1'b0;
        nxt_cnt = tick ? 16'h0000 : cnt_ff + 16'h0001;
        case (st_ff)
            E_IDLE: begin
                nxt_cnt = 16'h0000;
                if (cmd_valid) begin
                    nxt_sh = cmd_byte;
                    nxt_ph = 2'h0;
                    nxt_bit = 4'h0;
                    if (cmd_op == OP_START) begin
                        nxt_st = E_START;
                    end else if (cmd_op == OP_WRITE) begin
                        nxt_st = E_BIT;
                    end else begin
                        nxt_st = E_STOP;
                    end
                end
            end
            E_BIT: begin
                if (tick) begin
                    nxt_ph = ph_ff + 2'h1;
                    if (ph_ff == 2'h2 && bit_ff == 4'h8) begin
                        nxt_nack = s2_ff;
                    end
                    if (ph_ff == 2'h3) begin
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_bit = bit_ff + 4'h1;
                        if (bit_ff == 4'h8) begin
                            nxt_st = E_IDLE;
                            nxt_done = 1'b1;
                        end
                    end
                end
            end
            default: begin
                if (tick) begin
                    nxt_ph = ph_ff + 2'h1;
                    if (ph_ff == 2'h2) begin
                        nxt_st = E_IDLE;
                        nxt_done = 1'b1;
                    end
                end
            end
        endcase
        // line levels follow the next step; idle keeps the last levels
        nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff;
        case (nxt_st)
            E_START: begin
                nxt_scl_oe = (nxt_ph == 2'h2);
                nxt_sda_oe = (nxt_ph != 2'h0);
            end
            E_BIT: begin
                nxt_scl_oe = (nxt_ph == 2'h0) || (nxt_ph == 2'h3);
                nxt_sda_oe = (nxt_bit != 4'h8) && !nxt_sh[7];
            end
            E_STOP: begin
                nxt_scl_oe = (nxt_ph == 2'h0);
                nxt_sda_oe = (nxt_ph != 2'h2);
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= E_IDLE;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            cnt_ff <= 16'h0000;
            sh_ff <= 8'h00;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            done_ff <= 1'b0;
            nack_ff <= 1'b0;
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            ph_ff <= nxt_ph;
            bit_ff <= nxt_bit;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
            done_ff <= nxt_done;
            nack_ff <= nxt_nack;
            s1_ff <= sda_i;
            s2_ff <= s1_ff;
        end
    end

    chk_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == E_BIT && bit_ff < 4'h8 && ph_ff == 2'h1) |-> (sda_oe_ff == !sh_ff[7]))
        else $error("data bit on the line is not the top bit of the shifter");
    chk_data_stable: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == E_BIT && ph_ff == 2'h1 && tick) |=> (!scl_oe_ff && $stable(sda_oe_ff)))
        else $error("data changed while the clock line was high");
endmodule

// [rtl/sicu_master.sv]
// apb-programmed controller that writes the synthesizer's instruction bytes
// assumes a zero-wait apb master on pclk and pull-ups on the two-wire bus
//
// Overview of operation
// - address byte is 11000, two select bits, then 0 for write.
// - divider byte 1: 0, two ref-select bits, two spare, factor bits 14-12.
// - divider bytes 2 and 3: two spare bits, then factor bits 11-6, 5-0.
// - control byte 1: 110, amp off, test, pump off, high, low select.
// - control byte 2: doubler off, boost, C, D, two spare, G, H.
// - control byte 3 is sent with its low seven bits zero.
// - converter byte 1 starts 10; bytes 2 and 3 carry codes A, B.
// - transfer is start, address, acknowledged bytes, stop.
// - bytes follow in group order; groups only continue to the next.
// - every byte goes most significant bit first.
// - main factor sent must lie between 2048 and 32767.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
module sicu_master import sicu_pkg::*; #(
    parameter int QTR = QTR_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // two-wire bus to the synthesizer
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_ADDR = 3'b010,
        S_DATA = 3'b011,
        S_STOP = 3'b100
    } sicu_state_t;

    sicu_state_t st_ff, nxt_st;
    logic [16:0] div_ff, nxt_div;
    logic [4:0] loop_ff, nxt_loop;
    logic [5:0] dsw_ff, nxt_dsw;
    logic [15:0] conv_ff, nxt_conv;
    logic [1:0] first_ff, nxt_first, last_ff, nxt_last, as_ff, nxt_as;
    logic [3:0] idx_ff, nxt_idx;
    logic wait_ff, nxt_wait;
    logic nack_ff, nxt_nack, done_ff, nxt_done, err_ff, nxt_err;
    logic [31:0] prdata_ff, nxt_prdata;
    logic wr, rd_setup, hit, go, go_ok;
    logic [1:0] go_first, go_last;
    logic [3:0] last_idx;
    logic eng_valid, eng_ready, eng_done, eng_nack;
    logic [1:0] eng_op;
    logic [7:0] eng_byte, addr_byte;

    // wire image of each instruction byte, index 0..8 over three groups
    function automatic logic [7:0] byte_at(input logic [3:0] i);
        case (i)
            4'h0: byte_at = {1'b0, div_ff[DIV_RD_FIRST_BIT], div_ff[DIV_RD_SECOND_BIT],
                             2'b00, div_ff[14:12]};
            4'h1: byte_at = {2'b00, div_ff[11:6]};
            4'h2: byte_at = {2'b00, div_ff[5:0]};
            4'h3: byte_at = {CTRL_PREFIX, loop_ff};
            4'h4: byte_at = {dsw_ff[5:2], 2'b00, dsw_ff[1:0]};
            4'h5: byte_at = 8'h00;
            4'h6: byte_at = {CONV_PREFIX, 6'h00};
            4'h7: byte_at = conv_ff[7:0];
            default: byte_at = conv_ff[15:8];
        endcase
    endfunction

    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !hit;
    assign go = wr && (paddr == OFF_CMD) && pwdata[CMD_GO_BIT];
    assign go_first = pwdata[CMD_FIRST_LSB +: 2];
    assign go_last = pwdata[CMD_LAST_LSB +: 2];
    // refuse an illegal group span and an out-of-range factor
    assign go_ok = (st_ff == S_IDLE) && (go_first <= go_last) && (go_last <= GRP_CONV) &&
                   (go_first != GRP_DIV || div_ff[14:0] >= MIN_FACTOR);
    assign last_idx = {2'b00, last_ff} * 4'h3 + 4'h2;
    assign addr_byte = {ADDR_PREFIX, as_ff, 1'b0};

    always_comb begin
        if (paddr == OFF_DIV || paddr == OFF_LOOP || paddr == OFF_DSW) begin
            hit = 1'b1;
        end else if (paddr == OFF_CONV || paddr == OFF_CMD || paddr == OFF_STAT) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // register file
    always_comb begin
        nxt_div = div_ff;
        nxt_loop = loop_ff;
        nxt_dsw = dsw_ff;
        nxt_conv = conv_ff;
        nxt_prdata = prdata_ff;
        if (wr && paddr == OFF_DIV) begin
            nxt_div = pwdata[16:0];
        end else if (wr && paddr == OFF_LOOP) begin
            nxt_loop = pwdata[4:0];
        end else if (wr && paddr == OFF_DSW) begin
            nxt_dsw = pwdata[5:0];
        end else if (wr && paddr == OFF_CONV) begin
            nxt_conv = pwdata[15:0];
        end
        if (rd_setup) begin
            if (paddr == OFF_DIV) begin
                nxt_prdata = {15'h0000, div_ff};
            end else if (paddr == OFF_LOOP) begin
                nxt_prdata = {27'h0000000, loop_ff};
            end else if (paddr == OFF_DSW) begin
                nxt_prdata = {26'h0000000, dsw_ff};
            end else if (paddr == OFF_CONV) begin
                nxt_prdata = {16'h0000, conv_ff};
            end else if (paddr == OFF_CMD) begin
                nxt_prdata = {26'h0000000, as_ff, last_ff, first_ff};
            end else if (paddr == OFF_STAT) begin
                nxt_prdata = {28'h0000000, err_ff, done_ff, nack_ff, st_ff != S_IDLE};
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    // transfer sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_idx = idx_ff;
        nxt_wait = wait_ff;
        nxt_first = first_ff;
        nxt_last = last_ff;
        nxt_as = as_ff;
        nxt_nack = nack_ff;
        nxt_done = done_ff;
        nxt_err = err_ff;
        eng_valid = 1'b0;
        eng_op = OP_WRITE;
        eng_byte = (st_ff == S_ADDR) ? addr_byte : byte_at(idx_ff);
        if (go && st_ff == S_IDLE) begin
            nxt_err = !go_ok;
            if (go_ok) begin
                nxt_first = go_first;
                nxt_last = go_last;
                nxt_as = pwdata[CMD_AS_LSB +: 2];
                nxt_idx = {2'b00, go_first} * 4'h3;
                nxt_nack = 1'b0;
                nxt_done = 1'b0;
                nxt_st = S_START;
            end
        end else if (st_ff != S_IDLE) begin
            if (!wait_ff && eng_ready) begin
                eng_valid = 1'b1;
                nxt_wait = 1'b1;
                if (st_ff == S_START) begin
                    eng_op = OP_START;
                end else if (st_ff == S_STOP) begin
                    eng_op = OP_STOP;
                end
            end
            if (eng_done) begin
                nxt_wait = 1'b0;
                case (st_ff)
                    S_START: nxt_st = S_ADDR;
                    S_ADDR: begin
                        nxt_nack = eng_nack;
                        nxt_st = eng_nack ? S_STOP : S_DATA;
                    end
                    S_DATA: begin
                        nxt_nack = eng_nack;
                        if (eng_nack || idx_ff == last_idx) begin
                            nxt_st = S_STOP;
                        end else begin
                            nxt_idx = idx_ff + 4'h1;
                        end
                    end
                    default: begin
                        nxt_st = S_IDLE;
                        nxt_done = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= S_IDLE;
            div_ff <= DIV_RESET;
            loop_ff <= LOOP_RESET;
            dsw_ff <= DSW_RESET;
            conv_ff <= CONV_RESET;
            first_ff <= 2'h0;
            last_ff <= 2'h0;
            as_ff <= 2'h0;
            idx_ff <= 4'h0;
            wait_ff <= 1'b0;
            nack_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            loop_ff <= nxt_loop;
            dsw_ff <= nxt_dsw;
            conv_ff <= nxt_conv;
            first_ff <= nxt_first;
            last_ff <= nxt_last;
            as_ff <= nxt_as;
            idx_ff <= nxt_idx;
            wait_ff <= nxt_wait;
            nack_ff <= nxt_nack;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            prdata_ff <= nxt_prdata;
        end
    end

    sicu_i2c_engine #(.QTR(QTR)) u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .cmd_valid(eng_valid),
        .cmd_op(eng_op),
        .cmd_byte(eng_byte),
        .cmd_ready(eng_ready),
        .done(eng_done),
        .nack(eng_nack),
        .sda_i(sda_i),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_issue_data;
        eng_valid && st_ff == S_DATA;
    endsequence

    chk_addr_byte: assert property ((eng_valid && st_ff == S_ADDR) |->
        (eng_byte[7:3] == 5'h18 && eng_byte[2:1] == as_ff && !eng_byte[0]))
        else $error("address byte malformed");
    chk_div_first: assert property ((seq_issue_data and idx_ff == 4'h0) |->
        (!eng_byte[7] && eng_byte[2:0] == div_ff[14:12]))
        else $error("first divider byte malformed");
    chk_div_low: assert property ((seq_issue_data and idx_ff == 4'h2) |->
        (eng_byte == {2'b00, div_ff[5:0]}))
        else $error("third divider byte malformed");
    chk_ctrl_prefix: assert property ((seq_issue_data and idx_ff == 4'h3) |->
        (eng_byte[7:5] == 3'h6 && eng_byte[0] == loop_ff[0]))
        else $error("first control byte malformed");
    chk_dsw_layout: assert property ((seq_issue_data and idx_ff == 4'h4) |->
        (eng_byte[3:2] == 2'b00 && eng_byte[7] == dsw_ff[5] && eng_byte[0] == dsw_ff[0]))
        else $error("second control byte malformed");
    chk_filler_zero: assert property ((seq_issue_data and idx_ff == 4'h5) |->
        (eng_byte[6:0] == 7'h00))
        else $error("third control byte not zero");
    chk_conv_prefix: assert property ((seq_issue_data and idx_ff == 4'h6) |->
        (eng_byte[7:6] == 2'h2))
        else $error("first converter byte malformed");
    chk_index_step: assert property ((st_ff == S_DATA && eng_done && !eng_nack &&
        idx_ff != last_idx) |=> (idx_ff == $past(idx_ff) + 4'h1 && st_ff == S_DATA))
        else $error("instruction byte index did not advance by one");
    chk_range_refuse: assert property ((go && st_ff == S_IDLE && go_first == 2'h0 &&
        div_ff[14:0] < 15'h0800) |=> (st_ff == S_IDLE && err_ff) [*2])
        else $error("out-of-range factor was sent");
    chk_start_first: assert property ((go && go_ok) |=>
        (st_ff == S_START) ##[0:8] (eng_valid && eng_op == 2'h0))
        else $error("transfer did not open with a start");
endmodule

// [tb/sicu_dev_model.sv]
// behavioural model of the write-only synthesizer control unit on the two-wire bus
// assumes scl and sda arrive resolved with pull-ups; it only samples them on pclk
`timescale 1ns/1ns
module sicu_dev_model (
    // clock
    input wire logic pclk,
    // bus and address pin level
    input wire logic scl,
    input wire logic sda,
    input wire logic [1:0] addr_pin,
    output logic sda_pull,
    // decoded state
    output logic [14:0] factor,
    output int ref_eff,
    output int pump_ua,
    output logic running,
    output int nbytes
);
    localparam int REF_TAB [4] = '{1120, 1152, 1024, 1536};
    localparam int CUR_TAB [4] = '{50, 102, 151, 203};
    logic [7:0] regs [9] = '{default: 8'h00};
    logic [7:0] stage [9];
    logic [8:0] wr = '0;
    logic [7:0] sh = '0;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic first = 1'b0;
    logic hit = 1'b0;
    int cnt = 0;
    int pos = -1;
    int lock_run = 0;
    logic lock;
    initial begin
        sda_pull = 1'b0;
        running = 1'b0;
        nbytes = 0;
    end
    always @(posedge pclk) begin
        if (scl && scl_q && sda_q && !sda) begin
            first = 1'b1;
            cnt = 0;
            wr = '0;
        end else if (scl && scl_q && !sda_q && sda) begin
            // staged bytes land only on stop, so a refused or cut transfer changes nothing
            for (int i = 0; i < 9; i++) if (hit && wr[i]) regs[i] = stage[i];
            if (hit && &wr[2:0]) running = 1'b1;
            hit = 1'b0;
        end else if (scl && !scl_q) begin
            if (cnt < 8) sh = {sh[6:0], sda};
            cnt = cnt + 1;
        end else if (!scl && scl_q && cnt == 9) begin
            sda_pull <= 1'b0;
            cnt = 0;
        end else if (!scl && scl_q && cnt == 8) begin
            if (first) begin
                hit = sh[7:3] == 5'b11000 && sh[2:1] == addr_pin && !sh[0];
                pos = -1;
                first = 1'b0;
            end else if (hit) begin
                if (pos >= 0) pos = pos + 1;
                else pos = !sh[7] ? 0 : sh[7:5] == 3'b110 ? 3 : sh[7:6] == 2'b10 ? 6 : 9;
                if (pos < 9) stage[pos] = sh;
                if (pos < 9) wr[pos] = 1'b1;
            end
            // non-blocking, so the controller never races the pull at the edge that samples it
            sda_pull <= hit;
            nbytes = nbytes + int'(hit);
        end
        scl_q = scl;
        sda_q = sda;
    end
    assign factor = {regs[0][2:0], regs[1][5:0], regs[2][5:0]};
    assign ref_eff = REF_TAB[{regs[0][5], regs[0][6]}];
    assign pump_ua = regs[3][2] ? 0 : CUR_TAB[regs[3][1:0]];
    // one comparison per pclk stands in for the detector rate; the ideal loop is always in window
    always @(posedge pclk) begin
        if (!running || regs[3][2]) lock_run <= 0;
        else if (lock_run < 7) lock_run <= lock_run + 1;
    end
    assign lock = (lock_run == 7);
endmodule

// [tb/tb_sicu_master.sv]
// testbench of the apb-programmed synthesizer controller against a device model
// assumes pull-ups on both wires; the bench resolves the open-drain levels itself
`timescale 1ns/1ns
module tb_sicu_master import sicu_pkg::*;;
    localparam int QTR = 4;
    localparam int LIMIT = 80000;
    int ref_tab [4] = '{1120, 1152, 1024, 1536};
    int cur_tab [4] = '{50, 102, 151, 203};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic scl_o, scl_oe, sda_o, sda_oe, scl, sda, dev_pull;
    logic [1:0] addr_pin;
    logic [14:0] factor;
    int ref_eff, pump_ua, nbytes, n0, fail_count, checks, cyc;
    logic running;
    assign scl = !scl_oe;
    assign sda = !(sda_oe || dev_pull);
    sicu_master #(.QTR(QTR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_o(sda_o), .sda_oe(sda_oe));
    sicu_dev_model dev (.pclk(pclk), .scl(scl), .sda(sda), .addr_pin(addr_pin),
        .sda_pull(dev_pull), .factor(factor), .ref_eff(ref_eff), .pump_ua(pump_ua),
        .running(running), .nbytes(nbytes));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one idle edge first, so a strobe is never lowered and raised in one time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic go(input logic [1:0] f, input logic [1:0] l, input logic [1:0] a);
        int n;
        n = 0;
        n0 = nbytes;
        apb(1'b1, OFF_CMD, {23'h0, 1'b1, 2'h0, a, l, f});
        rd = 32'h1;
        while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 3000) begin
            apb(1'b0, OFF_STAT, 32'h0);
            n++;
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        addr_pin = 2'h2;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd);
            chk("pslverr", 32'(i == 6), 32'(err));
        end
        chk("bus idle", 32'h0, 32'({scl_o, sda_o, scl_oe, sda_oe}));
        chk("dividers held", 32'h0, 32'(running));
        $display("test reset done");
        apb(1'b1, OFF_DIV, 32'h14d2b);
        apb(1'b1, OFF_LOOP, 32'h15);
        apb(1'b1, OFF_DSW, 32'h2b);
        apb(1'b1, OFF_CONV, 32'ha55a);
        go(2'h0, 2'h2, 2'h2);
        chk("status", 32'h4, rd);
        chk("bytes acked", 32'(n0 + 10), 32'(nbytes));
        chk("factor", 32'h4d2b, 32'(factor));
        chk("div1 top", 32'h0, 32'(dev.regs[0][7]));
        chk("ref factor", 32'(1152), 32'(ref_eff));
        chk("pump off", 32'h0, 32'(pump_ua));
        chk("ctl1", 32'hd5, 32'(dev.regs[3]));
        chk("ctl2", 32'ha3, 32'(dev.regs[4] & 8'hf3));
        chk("ctl3", 32'h0, 32'(dev.regs[5] & 8'h7f));
        chk("conv1", 32'h2, 32'(dev.regs[6][7:6]));
        chk("conv codes", 32'ha55a, 32'({dev.regs[8], dev.regs[7]}));
        chk("running", 32'h1, 32'(running));
        $display("test full transfer done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_DIV, {15'h0, 2'(i[0] + 2 * i[1]) == 2'h0 ? 2'h0 : {i[0], i[1]},
                i == 3 ? 15'h7fff : 15'(MIN_FACTOR + i)});
            apb(1'b1, OFF_LOOP, 32'(i));
            go(2'h0, 2'h1, 2'h2);
            chk("ref factor", 32'(ref_tab[i]), 32'(ref_eff));
            chk("pump current", 32'(cur_tab[i]), 32'(pump_ua));
            chk("factor", i == 3 ? 32'h7fff : 32'(MIN_FACTOR + i), 32'(factor));
        end
        chk("lock", 32'h1, 32'(dev.lock));
        $display("test divide and current done");
        apb(1'b1, OFF_DIV, 32'h07ff);
        for (int i = 0; i < 3; i++) begin
            go(i == 0 ? 2'h0 : i == 1 ? 2'h2 : 2'h1, i == 0 ? 2'h0 : i == 1 ? 2'h1 : 2'h3, 2'h2);
            // done stays up from the last accepted transfer; only an accepted go clears it
            chk("refused", 32'hc, rd & 32'hf);
            chk("no traffic", 32'(n0), 32'(nbytes));
        end
        chk("factor kept", 32'h7fff, 32'(factor));
        $display("test refusals done");
        apb(1'b1, OFF_CONV, 32'h1234);
        go(2'h2, 2'h2, 2'h1);
        chk("nack status", 32'h6, rd);
        chk("codes kept", 32'ha55a, 32'({dev.regs[8], dev.regs[7]}));
        go(2'h2, 2'h2, 2'h2);
        chk("status", 32'h4, rd);
        chk("codes", 32'h1234, 32'({dev.regs[8], dev.regs[7]}));
        chk("ctl1 kept", 32'hc3, 32'(dev.regs[3]));
        chk("factor kept", 32'h7fff, 32'(factor));
        $display("test address and partial group done");
        final_report();
    end
endmodule
